// ==== rtl/pmbus_ctrl_map.svh ====
// Offsets, field positions, reset values and timing counts of the controller.
`ifndef PMBUS_CTRL_MAP_SVH
`define PMBUS_CTRL_MAP_SVH

// Wishbone register byte offsets.
`define REG_OPERATION     8'h00
`define REG_ON_OFF_CONFIG 8'h04
`define REG_VREF_TRIM     8'h08
`define REG_MARGIN_HIGH   8'h0C
`define REG_MARGIN_LOW    8'h10
`define REG_STATUS        8'h14
`define REG_VFB_REF       8'h18

// Link command codes.
`define CMD_OPERATION     8'h01
`define CMD_ON_OFF_CONFIG 8'h02
`define CMD_VREF_TRIM     8'hD4
`define CMD_MARGIN_HIGH   8'hD5
`define CMD_MARGIN_LOW    8'hD6

// OPERATION fields.
`define OP_ON_BIT         7
`define OP_MARGIN_HI      5
`define OP_MARGIN_LO      4
`define OP_RESET          8'h00

// ON_OFF_CONFIG fields.
`define CFG_POWERUP_BIT   4
`define CFG_CMD_BIT       3
`define CFG_PIN_BIT       2
`define CFG_POL_BIT       1
`define CFG_RESET         8'h16

// Linear format: mantissa counts of 2^-9 V, close to 2 mV per step.
`define VOUT_EXPONENT     (-9)
`define VREF_NOM_MANT     18'sh00133
`define TRIM_MIN_PCT      20
`define TRIM_MAX_PCT      10
`define TOTAL_MIN_PCT     30
`define TOTAL_MAX_PCT     10

// Bus address strap.
`define ADDR_FALLBACK     7'h7F
`define DIGIT_MAX         4'h7

// Strap settle time after reset release.
`define CLK_MHZ           10
`define STRAP_SETTLE_US   100
`define STRAP_SETTLE_CYC  (`STRAP_SETTLE_US * `CLK_MHZ)

`endif

// ==== rtl/pmbus_ctrl_pkg.sv ====
// Types shared by the controller modules.
package pmbus_ctrl_pkg;
    typedef enum logic [1:0] {MODE_ALWAYS, MODE_PIN, MODE_CMD, MODE_BOTH}
        onoff_mode_e;
    typedef enum logic [1:0] {MARGIN_NONE, MARGIN_LOW, MARGIN_HIGH}
        margin_e;
    typedef enum logic {STRAP_WAIT, STRAP_DONE} strap_state_e;
    typedef logic signed [15:0] lin_mant_t;
endpackage

// ==== rtl/addr_strap_decode.sv ====
// Latches the strapped address digits once after reset.
`timescale 1ns/1ns
`include "pmbus_ctrl_map.svh"
module addr_strap_decode #(
    parameter int SETTLE_CYC = `STRAP_SETTLE_CYC
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] digit_high_i,
    input  wire logic [3:0] digit_low_i,
    output logic      [6:0] addr_o,
    output logic            fault_o,
    output logic            done_o
);
    pmbus_ctrl_pkg::strap_state_e state_q;
    logic [15:0]                  wait_q;

    // Count out the settle time, then sample the digits exactly once.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= pmbus_ctrl_pkg::STRAP_WAIT;
            wait_q  <= 16'h0000;
            addr_o  <= `ADDR_FALLBACK;
            fault_o <= 1'b0;
        end else if (state_q == pmbus_ctrl_pkg::STRAP_WAIT) begin
            wait_q <= wait_q + 16'h0001;
            if (wait_q == 16'(SETTLE_CYC - 1)) begin
                state_q <= pmbus_ctrl_pkg::STRAP_DONE; // RL16
                if (digit_high_i > `DIGIT_MAX || digit_low_i > `DIGIT_MAX) begin
                    addr_o  <= `ADDR_FALLBACK; // RL8
                    fault_o <= 1'b1;
                end else begin
                    addr_o  <= {1'b0, digit_high_i[2:0], digit_low_i[2:0]}; // RL7
                    fault_o <= 1'b0;
                end
            end
        end
    end

    assign done_o = (state_q == pmbus_ctrl_pkg::STRAP_DONE);
endmodule

// ==== rtl/vref_calc.sv ====
// Feedback reference from trim and margin steps, in linear mantissa units.
`timescale 1ns/1ns
`include "pmbus_ctrl_map.svh"
module vref_calc (
    input  wire pmbus_ctrl_pkg::lin_mant_t trim_i,
    input  wire pmbus_ctrl_pkg::lin_mant_t margin_high_i,
    input  wire pmbus_ctrl_pkg::lin_mant_t margin_low_i,
    input  wire pmbus_ctrl_pkg::margin_e   margin_i,
    output pmbus_ctrl_pkg::lin_mant_t      vfb_o
);
    localparam logic signed [17:0] NOM = `VREF_NOM_MANT;
    // The percentage products are 32 bits wide; the bounds fit in 18.
    localparam logic signed [17:0] TRIM_LO =
        18'(-(NOM * `TRIM_MIN_PCT) / 100);
    localparam logic signed [17:0] TRIM_HI =
        18'((NOM * `TRIM_MAX_PCT) / 100);
    localparam logic signed [17:0] TOT_LO =
        18'(-(NOM * `TOTAL_MIN_PCT) / 100);
    localparam logic signed [17:0] TOT_HI =
        18'((NOM * `TOTAL_MAX_PCT) / 100);

    function automatic logic signed [17:0] clamp(input logic signed [17:0] v,
        input logic signed [17:0] lo, input logic signed [17:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    logic signed [17:0] trim_c;
    logic signed [17:0] step_c;
    logic signed [17:0] total_c;

    // Trim is held to its own span, then margin plus trim to the wider one.
    always_comb begin
        trim_c = clamp(18'(trim_i), TRIM_LO, TRIM_HI); // RL11 RL12
        unique case (margin_i) // RL14
            pmbus_ctrl_pkg::MARGIN_HIGH: step_c = 18'(margin_high_i);
            pmbus_ctrl_pkg::MARGIN_LOW:  step_c = 18'(margin_low_i);
            default:                     step_c = 18'sh00000;
        endcase
        total_c = clamp(trim_c + step_c, TOT_LO, TOT_HI); // RL13
        vfb_o   = 16'(NOM + total_c); // RL15 RL10
    end
endmodule

// ==== rtl/pmbus_onoff_ctrl.sv ====
// On/off, address strap, two-phase and reference control of a buck pair.
//
// Notes on behaviour
// RL1: Command-only mode follows OPERATION, ignores pin.
// RL2: Combined mode needs pin and OPERATION on.
// RL3: Pin-only mode follows enable pin alone.
// RL4: Enable pin polarity is configurable.
// RL5: Channel-2 feedback at bias rail selects two-phase.
// RL6: Sixty-four addresses, zero to sixty-three.
// RL7: High pin upper octal digit, low pin lower.
// RL8: Out-of-range strap answers at address 127.
// RL9: Link works at standard and fast speeds.
// RL10: Numeric arguments use linear mantissa-exponent format.
// RL11: Trim spans minus twenty to plus ten percent.
// RL12: Trim resolution is two millivolts.
// RL13: Margin plus trim held within -30/+10 percent.
// RL14: OPERATION picks none, high or low margin.
// RL15: Reference is 0.6 V, trim, plus margin.
// RL16: Address digits latched once after power-up.
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`include "pmbus_ctrl_map.svh"
module pmbus_onoff_ctrl #(
    parameter int STRAP_SETTLE = `STRAP_SETTLE_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    input  wire logic        link_clk_i,
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire logic [6:0]  cmd_addr_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [15:0] cmd_data_i,
    input  wire logic        enable_control_pin_i,
    input  wire logic        channel2_feedback_pin_i,
    input  wire logic [3:0]  address_digit_low_pin_i,
    input  wire logic [3:0]  address_digit_high_pin_i,
    output logic             regulate_o,
    output logic             two_phase_o,
    output logic [6:0]       bus_address_o,
    output logic             addr_fault_o,
    output logic [15:0]      vfb_ref_o
);
    localparam int NPIN = 10;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: three stages, a change counts when 2 and 3 agree.
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1_q;
    logic [NPIN-1:0] pin_s2_q;
    logic [NPIN-1:0] pin_s3_q;
    logic [NPIN-1:0] pin_q;

    assign pin_raw = {address_digit_high_pin_i, address_digit_low_pin_i,
                      channel2_feedback_pin_i, enable_control_pin_i};

    // One filtered stage per pin bit.
    for (genvar g = 0; g < NPIN; g++) begin : g_pin_sync
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pin_s1_q[g] <= 1'b0;
                pin_s2_q[g] <= 1'b0;
                pin_s3_q[g] <= 1'b0;
                pin_q[g]    <= 1'b0;
            end else begin
                pin_s1_q[g] <= pin_raw[g];
                pin_s2_q[g] <= pin_s1_q[g];
                pin_s3_q[g] <= pin_s2_q[g];
                if (pin_s2_q[g] == pin_s3_q[g]) begin
                    pin_q[g] <= pin_s3_q[g];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers, written from Wishbone or from the link.
    logic [7:0]                operation_q;
    logic [7:0]                onoff_cfg_q;
    pmbus_ctrl_pkg::lin_mant_t trim_q;
    pmbus_ctrl_pkg::lin_mant_t mhigh_q;
    pmbus_ctrl_pkg::lin_mant_t mlow_q;
    logic                      wb_wr;
    logic                      lk_wr;
    logic [7:0]                lk_code_q;
    logic [15:0]               lk_data_q;
    logic [6:0]                lk_addr_q;

    // Merges byte enables into an old word value.
    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [31:0] wd, input logic [3:0] sel);
        merge16 = {sel[1] ? wd[15:8] : old[15:8], sel[0] ? wd[7:0] : old[7:0]};
    endfunction

    // Wishbone write hits register at offset.
    function automatic logic wb_hit(input logic [7:0] off);
        wb_hit = wb_wr && (adr_i == off);
    endfunction

    // Link write hits command code.
    function automatic logic lk_hit(input logic [7:0] code);
        lk_hit = lk_wr && (lk_code_q == code);
    endfunction

    // OPERATION; a Wishbone write and a link write in one cycle: bus wins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            operation_q <= `OP_RESET;
        end else if (wb_hit(`REG_OPERATION) && sel_i[0]) begin
            operation_q <= dat_i[7:0];
        end else if (lk_hit(`CMD_OPERATION)) begin
            operation_q <= lk_data_q[7:0];
        end
    end

    // ON_OFF_CONFIG.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            onoff_cfg_q <= `CFG_RESET;
        end else if (wb_hit(`REG_ON_OFF_CONFIG) && sel_i[0]) begin
            onoff_cfg_q <= dat_i[7:0];
        end else if (lk_hit(`CMD_ON_OFF_CONFIG)) begin
            onoff_cfg_q <= lk_data_q[7:0];
        end
    end

    // Trim and margin steps; mantissas with a fixed exponent of -9.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trim_q  <= 16'sh0000;
            mhigh_q <= 16'sh0000;
            mlow_q  <= 16'sh0000;
        end else begin
            if (wb_hit(`REG_VREF_TRIM)) begin
                trim_q <= merge16(trim_q, dat_i, sel_i); // RL10
            end else if (lk_hit(`CMD_VREF_TRIM)) begin
                trim_q <= lk_data_q;
            end
            if (wb_hit(`REG_MARGIN_HIGH)) begin
                mhigh_q <= merge16(mhigh_q, dat_i, sel_i);
            end else if (lk_hit(`CMD_MARGIN_HIGH)) begin
                mhigh_q <= lk_data_q;
            end
            if (wb_hit(`REG_MARGIN_LOW)) begin
                mlow_q <= merge16(mlow_q, dat_i, sel_i);
            end else if (lk_hit(`CMD_MARGIN_LOW)) begin
                mlow_q <= lk_data_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address strap and reference.
    logic                      strap_done;
    logic [6:0]                strap_addr;
    logic                      strap_fault;
    pmbus_ctrl_pkg::margin_e   margin_sel;
    pmbus_ctrl_pkg::lin_mant_t vfb_c;

    addr_strap_decode #(
        .SETTLE_CYC (STRAP_SETTLE)
    ) u_strap (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .digit_high_i (pin_q[9:6]),
        .digit_low_i  (pin_q[5:2]),
        .addr_o       (strap_addr),
        .fault_o      (strap_fault),
        .done_o       (strap_done)
    );

    // Margin bits of OPERATION choose the step; both set means no margin.
    always_comb begin
        unique case ({operation_q[`OP_MARGIN_HI], operation_q[`OP_MARGIN_LO]})
            2'b10:   margin_sel = pmbus_ctrl_pkg::MARGIN_HIGH; // RL14
            2'b01:   margin_sel = pmbus_ctrl_pkg::MARGIN_LOW;
            default: margin_sel = pmbus_ctrl_pkg::MARGIN_NONE;
        endcase
    end

    vref_calc u_vref (
        .trim_i        (trim_q),
        .margin_high_i (mhigh_q),
        .margin_low_i  (mlow_q),
        .margin_i      (margin_sel),
        .vfb_o         (vfb_c)
    );

    ////////////////////////////////////////////////////////////////////////
    // Regulation enable.
    pmbus_ctrl_pkg::onoff_mode_e mode;
    logic                        pin_on;
    logic                        op_on;
    logic                        regulate_d;

    assign pin_on = pin_q[0] ~^ onoff_cfg_q[`CFG_POL_BIT]; // RL4
    assign op_on  = operation_q[`OP_ON_BIT];

    // Mode from the config bits; with power-up bit clear the unit just runs.
    always_comb begin
        if (!onoff_cfg_q[`CFG_POWERUP_BIT]) begin
            mode = pmbus_ctrl_pkg::MODE_ALWAYS;
        end else begin
            unique case ({onoff_cfg_q[`CFG_CMD_BIT], onoff_cfg_q[`CFG_PIN_BIT]})
                2'b10:   mode = pmbus_ctrl_pkg::MODE_CMD;
                2'b01:   mode = pmbus_ctrl_pkg::MODE_PIN;
                2'b11:   mode = pmbus_ctrl_pkg::MODE_BOTH;
                default: mode = pmbus_ctrl_pkg::MODE_ALWAYS;
            endcase
        end
        unique case (mode)
            pmbus_ctrl_pkg::MODE_CMD:  regulate_d = op_on;           // RL1
            pmbus_ctrl_pkg::MODE_PIN:  regulate_d = pin_on;          // RL3
            pmbus_ctrl_pkg::MODE_BOTH: regulate_d = op_on && pin_on; // RL2
            pmbus_ctrl_pkg::MODE_ALWAYS: regulate_d = 1'b1;
        endcase
    end

    // Outputs to the power stage, all from flip-flops.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regulate_o    <= 1'b0;
            two_phase_o   <= 1'b0;
            bus_address_o <= `ADDR_FALLBACK;
            addr_fault_o  <= 1'b0;
            vfb_ref_o     <= 16'h0000;
        end else begin
            regulate_o    <= regulate_d && strap_done;
            two_phase_o   <= pin_q[1]; // RL5
            bus_address_o <= strap_addr; // RL6
            addr_fault_o  <= strap_fault;
            vfb_ref_o     <= vfb_c;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the strobe, write at the ack edge.
    logic [31:0] rd_c;

    assign wb_wr = cyc_i && stb_i && we_i && ack_o;

    // Read mux; unmapped offsets read as zero and are still acknowledged.
    always_comb begin
        unique case (adr_i)
            `REG_OPERATION:     rd_c = {24'h000000, operation_q};
            `REG_ON_OFF_CONFIG: rd_c = {24'h000000, onoff_cfg_q};
            `REG_VREF_TRIM:     rd_c = {16'h0000, trim_q};
            `REG_MARGIN_HIGH:   rd_c = {16'h0000, mhigh_q};
            `REG_MARGIN_LOW:    rd_c = {16'h0000, mlow_q};
            `REG_STATUS:        rd_c = {20'h00000, strap_done, addr_fault_o,
                                        two_phase_o, regulate_o, 1'b0,
                                        bus_address_o};
            `REG_VFB_REF:       rd_c = {16'h0000, vfb_ref_o};
            default:            rd_c = 32'h00000000;
        endcase
    end

    // Ack drops the cycle after it is given, so each access takes two cycles.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (cyc_i && stb_i && !ack_o && !we_i) begin
                dat_o <= rd_c;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link side: commands taken on the link clock, handed over by toggle.
    logic lrst_s1_q;
    logic lrst_q;
    logic req_tgl_q;
    logic ack_s1_q;
    logic ack_s2_q;
    logic ack_s3_q;
    logic ack_seen_q;
    logic ack_tgl_q;
    logic take;

    // Reset reaches the link domain through two stages.
    always_ff @(posedge link_clk_i) begin
        lrst_s1_q <= rst_i;
        lrst_q    <= lrst_s1_q;
    end

    // Only one command is in flight; the link is stalled until it returns.
    assign take = cmd_valid_i && cmd_ready_o; // RL9

    always_ff @(posedge link_clk_i) begin
        if (lrst_q) begin
            req_tgl_q   <= 1'b0;
            cmd_ready_o <= 1'b0;
            lk_code_q   <= 8'h00;
            lk_data_q   <= 16'h0000;
            lk_addr_q   <= 7'h00;
        end else begin
            if (take) begin
                req_tgl_q <= !req_tgl_q;
                lk_code_q <= cmd_code_i;
                lk_data_q <= cmd_data_i;
                lk_addr_q <= cmd_addr_i;
            end
            cmd_ready_o <= !take && (req_tgl_q == ack_seen_q);
        end
    end

    // Return toggle is filtered the same way as a pin.
    always_ff @(posedge link_clk_i) begin
        if (lrst_q) begin
            ack_s1_q   <= 1'b0;
            ack_s2_q   <= 1'b0;
            ack_s3_q   <= 1'b0;
            ack_seen_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
            if (ack_s2_q == ack_s3_q) begin
                ack_seen_q <= ack_s3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System side of the handover; held words are stable while pending.
    logic req_s1_q;
    logic req_s2_q;
    logic req_s3_q;
    logic req_new;

    assign req_new = (req_s2_q == req_s3_q) && (req_s3_q != ack_tgl_q);
    assign lk_wr   = req_new && strap_done && (lk_addr_q == bus_address_o);

    // Commands to other addresses are dropped but still returned.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_s1_q  <= 1'b0;
            req_s2_q  <= 1'b0;
            req_s3_q  <= 1'b0;
            ack_tgl_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            if (req_new) begin
                ack_tgl_q <= req_s3_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the system clock.
    sequence s_cmd_mode_on;
        mode == pmbus_ctrl_pkg::MODE_CMD && op_on && strap_done;
    endsequence

    property p_cmd_only;
        @(posedge clk_i) disable iff (rst_i)
        s_cmd_mode_on |=> regulate_o;
    endproperty
    a_cmd_only: assert property (p_cmd_only) // RL1
        else $error("command mode on but regulation off");

    property p_both_pin_off;
        @(posedge clk_i) disable iff (rst_i)
        mode == pmbus_ctrl_pkg::MODE_BOTH && !pin_on |=> !regulate_o;
    endproperty
    a_both_pin_off: assert property (p_both_pin_off) // RL2
        else $error("combined mode regulates with pin off");

    property p_pin_only;
        @(posedge clk_i) disable iff (rst_i)
        mode == pmbus_ctrl_pkg::MODE_PIN && strap_done
            |=> regulate_o == $past(pin_on);
    endproperty
    a_pin_only: assert property (p_pin_only) // RL3 RL4
        else $error("pin mode does not follow the enable pin");

    property p_two_phase;
        @(posedge clk_i) disable iff (rst_i)
        $rose(pin_s3_q[1]) && pin_s2_q[1] |=> ##[1:2] two_phase_o;
    endproperty
    a_two_phase: assert property (p_two_phase) // RL5
        else $error("two-phase not entered after feedback strap");

    property p_fallback;
        @(posedge clk_i) disable iff (rst_i)
        strap_done && strap_fault |=> bus_address_o == `ADDR_FALLBACK;
    endproperty
    a_fallback: assert property (p_fallback) // RL8
        else $error("out-of-range strap not at fallback address");

    property p_addr_range;
        @(posedge clk_i) disable iff (rst_i)
        strap_done && !strap_fault |=> bus_address_o < 7'h40;
    endproperty
    a_addr_range: assert property (p_addr_range) // RL6 RL7
        else $error("strapped address above sixty-three");

    property p_addr_hold;
        @(posedge clk_i) disable iff (rst_i)
        strap_done ##1 strap_done |=> $stable(bus_address_o);
    endproperty
    a_addr_hold: assert property (p_addr_hold) // RL16
        else $error("bus address changed after latching");

    property p_vfb_span;
        @(posedge clk_i) disable iff (rst_i)
        strap_done |-> $signed(vfb_ref_o) >= 16'sh00D7
            && $signed(vfb_ref_o) <= 16'sh0151;
    endproperty
    a_vfb_span: assert property (p_vfb_span) // RL13 RL15
        else $error("feedback reference outside allowed span");

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("bus ack held for two cycles");
endmodule

// ==== dv/link_host_model.sv ====
// Link-side host model that issues one command beat at a time.
`timescale 1ns/1ns
module link_host_model (
    input  wire logic        link_clk_i,
    input  wire logic        cmd_ready_i,
    output logic             cmd_valid_o = 1'b0,
    output logic [6:0]       cmd_addr_o = 7'h00,
    output logic [7:0]       cmd_code_o = 8'h00,
    output logic [15:0]      cmd_data_o = 16'h0000
);
    logic rdy_q = 1'b0;
    // Ready only moves on rising edges, so the falling edge shows its value.
    always @(negedge link_clk_i) rdy_q = cmd_ready_i;
    // The beat is held until ready is seen; idle lines show inverted data.
    task automatic send(input logic [6:0] a, input logic [7:0] c,
                        input logic [15:0] d, output bit ok);
        int n;
        n = 0;
        @(posedge link_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_addr_o  <= a;
        cmd_code_o  <= c;
        cmd_data_o  <= d;
        do begin @(posedge link_clk_i); n++; end while (!rdy_q && n < 99);
        cmd_valid_o <= 1'b0;
        cmd_addr_o  <= ~a;
        cmd_code_o  <= ~c;
        cmd_data_o  <= ~d;
        // Ready drops on the take edge itself, so skip past that first.
        repeat (2) @(posedge link_clk_i);
        while (!rdy_q && n < 99) begin @(posedge link_clk_i); n++; end
        ok = (n < 99);
    endtask
endmodule

// ==== dv/pmbus_onoff_ctrl_tb.sv ====
// Self-checking bench for the on/off, strap and reference controller.
`timescale 1ns/1ns
module pmbus_onoff_ctrl_tb;
    localparam int SETTLE = 20;
    logic clk_i = 1'b0, rst_i = 1'b1, lclk = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic we = 1'b0, en_pin = 1'b0, fb2 = 1'b0, ack_o, rdy, vld;
    logic [3:0] sel = 4'h0, dhi, dlo;
    logic [7:0] adr = 8'h00, code;
    logic [31:0] wdat = 32'h0, dat_o;
    logic [6:0] ba, caddr;
    logic [15:0] cdata;
    logic regulate_o, two_phase_o, addr_fault_o;
    logic [6:0] bus_address_o;
    logic [15:0] vfb_ref_o;
    logic [31:0] exp_q[$];
    int n_fail = 0, num_checks = 0;
    int tr[4] = '{0, 40, -61, 5};
    int mh[4] = '{0, 20, 0, 10};
    int ml[4] = '{0, 0, -40, 0};
    logic [7:0] opv[4] = '{8'h80, 8'hA0, 8'h90, 8'hA0};
    always #50 clk_i = ~clk_i;
    always #32 lclk = ~lclk;
    pmbus_onoff_ctrl #(.STRAP_SETTLE(SETTLE)) u_dut (.clk_i(clk_i),
        .rst_i(rst_i), .adr_i(adr), .dat_i(wdat), .dat_o(dat_o), .we_i(we),
        .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o),
        .link_clk_i(lclk), .cmd_valid_i(vld), .cmd_ready_o(rdy),
        .cmd_addr_i(caddr), .cmd_code_i(code), .cmd_data_i(cdata),
        .enable_control_pin_i(en_pin), .channel2_feedback_pin_i(fb2),
        .address_digit_low_pin_i(dlo), .address_digit_high_pin_i(dhi),
        .regulate_o(regulate_o), .two_phase_o(two_phase_o),
        .bus_address_o(bus_address_o), .addr_fault_o(addr_fault_o),
        .vfb_ref_o(vfb_ref_o));
    link_host_model lh (.link_clk_i(lclk), .cmd_ready_i(rdy),
        .cmd_valid_o(vld), .cmd_addr_o(caddr), .cmd_code_o(code),
        .cmd_data_o(cdata));
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    // Classic cycle: request held until ack is seen, then one idle cycle.
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'hF};
        adr <= a;
        wdat <= d;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
        {cyc, stb} <= 2'b00;
        if (n >= 50) begin n_fail++; complete_run(); end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb(a, 1'b0, 32'h0);
    endtask
    task automatic lsend(input logic [6:0] a, input logic [7:0] c, input int d);
        bit ok;
        lh.send(a, c, 16'(d), ok);
        check(32'(ok), 32'h1);
        if (!ok) complete_run();
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic strap(input logic [3:0] h, input logic [3:0] l);
        @(posedge clk_i);
        {dhi, dlo} <= {h, l};
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (SETTLE + 8) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // Read data is compared against the oldest queued expectation.
    always @(negedge clk_i) if (ack_o === 1'b1 && we === 1'b0) begin
        if (exp_q.size() == 0) begin n_fail++; complete_run(); end
        check(dat_o, exp_q.pop_front());
    end
    initial begin
        int t, e, m, pol, op, pin;
        void'($urandom(32'hc485));
        strap(4'($urandom_range(7)), 4'($urandom_range(7)));
        ba = {dhi[2:0], dlo[2:0]};
        check(32'(bus_address_o), 32'(ba));
        check(32'(addr_fault_o), 32'h0);
        rd(8'h00, 32'h00);
        rd(8'h04, 32'h16);
        rd(8'h1C, 32'h00);
        dhi <= ~dhi;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        check(32'(bus_address_o), 32'(ba));
        // Mode 3 clears the power-up bit, so the unit must simply run.
        for (int i = 0; i < 32; i++) begin
            {m, pol, op, pin} = {i / 8, (i / 4) % 2, (i / 2) % 2, i % 2};
            wb(8'h04, 1'b1, (m < 3 ? 32'h10 : 0) | (m != 1 ? 32'h8 : 0) |
                (m != 0 ? 32'h4 : 0) | (pol ? 32'h2 : 0));
            wb(8'h00, 1'b1, op ? 32'h80 : 32'h0);
            {en_pin, fb2} <= {pin[0], pin[0] ^ pol[0]};
            repeat (10) @(posedge clk_i);
            @(negedge clk_i);
            e = m == 0 ? op : (m == 1 ? pin == pol : op && pin == pol);
            if (m == 3) e = 1;
            check(32'(regulate_o), 32'(e));
            check(32'(two_phase_o), 32'(pin ^ pol));
        end
        for (int k = 0; k < 4; k++) begin
            t = k == 0 ? int'($urandom_range(91)) - 61 : tr[k];
            wb(8'h0C, 1'b1, {16'h0, 16'(mh[k])});
            wb(8'h10, 1'b1, {16'h0, 16'(ml[k])});
            lsend(ba, 8'hD4, t);
            lsend(ba, 8'h01, opv[k]);
            e = t < -61 ? -61 : (t > 30 ? 30 : t);
            e += opv[k][5] ? mh[k] : (opv[k][4] ? ml[k] : 0);
            e = 307 + (e < -92 ? -92 : (e > 30 ? 30 : e));
            check(32'(vfb_ref_o), 32'(e));
            rd(8'h18, 32'(e));
        end
        lsend(ba ^ 7'h01, 8'hD4, 7);
        lsend(ba, 8'h55, 7);
        check(32'(vfb_ref_o), 32'(e));
        strap(4'h8, 4'h2);
        check(32'(bus_address_o), 32'h7F);
        check(32'(addr_fault_o), 32'h1);
        lsend(7'h7F, 8'hD4, 3);
        check(32'(vfb_ref_o), 32'h136);
        complete_run();
    end
endmodule
